// File: verilog/dfr_supervisor.sv
/*
 * dfr_supervisor: fault and warning supervisor of a motor drive converter.
 * Stops the drive on failures, flags warnings, clears failures by stop key,
 * digital input or a remote write pair, and runs limited automatic restarts.
 * Assumes all inputs synchronous to clk_sys and an APB master for setup.
 */
// Notes on behaviour
// - failure stops drive, steady red, message
// - no run until cause gone and cleared
// - warning keeps running, message, flashing red
// - warning clears at motor standstill
// - parameter access never blocked by faults
// - stop key held 2 s clears failure
// - selected digital input clears failure
// - two successive remote writes clear failure
// - cleared with cause present: hold ready
// - ready state restarts once cause gone
// - restarts limited to count per window
// - restart waits delay after cause gone
// - limit reached waits for clear or window end
// - auto restart only for enabled types
// - code 3 for high DC voltage
// - code 5 for short circuit
// - code 6 for excessive current
`timescale 1ns/1ps

module dfr_supervisor
#(
	parameter int TICK_CYCLES = dfr_pkg::DFR_TICK_CYCLES
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        fault_low_udc,
	input  wire logic        fault_high_udc,
	input  wire logic        fault_short,
	input  wire logic        fault_high_cur,
	input  wire logic        fault_heatsink,
	input  wire logic        fault_analog,
	input  wire logic        warn_in,
	input  wire logic        motor_standstill,
	input  wire logic        stop_key,
	input  wire logic [7:0]  din,
	output logic             run_enable,
	output logic             red_led,
	output logic             show_failure,
	output logic             show_warning,
	output logic             ready_to_restart,
	output logic [3:0]       failure_code
);
	import dfr_pkg::*;

	localparam logic [16:0] TICK_LAST  = 17'(TICK_CYCLES - 1);
	localparam logic [10:0] KEY_LAST   = 11'(DFR_STOP_HOLD_MS - 1);
	localparam logic [15:0] BLINK_LAST = 16'(DFR_BLINK_HALF_MS - 1);

	dfr_regs_t s_reg;
	dfr_regs_t s_next;

	// failure cause and its code, by priority
	logic       cause;
	logic [3:0] new_code;
	logic       new_auto;

	always_comb
	begin
		cause = fault_short | fault_high_cur | fault_high_udc | fault_low_udc
			| fault_heatsink | fault_analog;
		new_code = DFR_CODE_NONE;
		new_auto = 1'b0;
		if (fault_short)
			new_code = DFR_CODE_SHORT;     // never restarts by itself
		else if (fault_high_cur)
		begin
			new_code = DFR_CODE_HIGH_CUR;
			new_auto = s_reg.auto_en[DFR_EN_HIGH_CUR];
		end
		else if (fault_high_udc)
		begin
			new_code = DFR_CODE_HIGH_UDC;
			new_auto = s_reg.auto_en[DFR_EN_HIGH_UDC];
		end
		else if (fault_low_udc)
		begin
			new_code = DFR_CODE_LOW_UDC;
			new_auto = s_reg.auto_en[DFR_EN_LOW_UDC];
		end
		else if (fault_heatsink)
		begin
			new_code = DFR_CODE_HEATSINK;
			new_auto = s_reg.auto_en[DFR_EN_HEATSINK];
		end
		else if (fault_analog)
		begin
			new_code = DFR_CODE_ANALOG;
			new_auto = s_reg.auto_en[DFR_EN_ANALOG];
		end
	end

	// next state of the whole supervisor
	logic wr;
	logic remote_clear;
	logic key_clear;
	logic din_clear;
	logic clear;

	always_comb
	begin
		s_next = s_reg;
		remote_clear = 1'b0;

		// millisecond time base
		if (s_reg.tick_cnt == TICK_LAST)
		begin
			s_next.tick_cnt = '0;
			s_next.tick = 1'b1;
		end
		else
		begin
			s_next.tick_cnt = s_reg.tick_cnt + 17'h00001;
			s_next.tick = 1'b0;
		end

		// apb setup phase: answer in the following access cycle
		s_next.pready = psel & ~penable;
		s_next.pslverr = 1'b0;
		s_next.prdata = '0;
		if (paddr == DFR_OFF_CTRL)
		begin
			s_next.prdata[DFR_CTRL_REMOTE_BIT] = s_reg.remote_en;
			s_next.prdata[DFR_CTRL_DIN_LSB +: DFR_DIN_SEL_W] = s_reg.din_sel;
			s_next.prdata[DFR_CTRL_AUTO_LSB +: DFR_AUTO_W] = s_reg.auto_en;
		end
		else if (paddr == DFR_OFF_MAX_CNT)
			s_next.prdata[7:0] = s_reg.max_cnt;
		else if (paddr == DFR_OFF_WINDOW)
			s_next.prdata[15:0] = s_reg.win_len;
		else if (paddr == DFR_OFF_DELAY)
			s_next.prdata[15:0] = s_reg.delay_len;
		else if (paddr == DFR_OFF_STATUS)
		begin
			s_next.prdata[DFR_STAT_ST_LSB +: 2] = s_reg.st;
			s_next.prdata[DFR_STAT_WARN_BIT] = s_reg.warn;
			s_next.prdata[DFR_STAT_CAUSE_BIT] = cause;
			s_next.prdata[DFR_STAT_CODE_LSB +: 4] = s_reg.code;
			s_next.prdata[DFR_STAT_CNT_LSB +: 8] = s_reg.rst_cnt;
			s_next.prdata[DFR_STAT_ARM_BIT] = s_reg.armed;
		end
		else if (paddr != DFR_OFF_REMOTE_CLR)
			s_next.pslverr = psel & ~penable; // unmapped; remote clear reads zero

		// apb writes; accepted in every supervisor state
		wr = psel & penable & s_reg.pready & pwrite & ~s_reg.pslverr;
		if (wr)
		begin
			if (paddr == DFR_OFF_REMOTE_CLR)
			begin
				if (pwdata[DFR_RCLR_BIT] & s_reg.armed)
				begin
					remote_clear = s_reg.remote_en;
					s_next.armed = 1'b0;
				end
				else
					s_next.armed = pwdata[DFR_RCLR_BIT] & s_reg.remote_en;
			end
			else
			begin
				// any other mapped write breaks the pair
				s_next.armed = 1'b0;
				if (paddr == DFR_OFF_CTRL)
				begin
					s_next.remote_en = pwdata[DFR_CTRL_REMOTE_BIT];
					s_next.din_sel = pwdata[DFR_CTRL_DIN_LSB +: DFR_DIN_SEL_W];
					s_next.auto_en = pwdata[DFR_CTRL_AUTO_LSB +: DFR_AUTO_W];
				end
				else if (paddr == DFR_OFF_MAX_CNT)
					s_next.max_cnt = pwdata[7:0];
				else if (paddr == DFR_OFF_WINDOW)
					s_next.win_len = pwdata[15:0];
				else if (paddr == DFR_OFF_DELAY)
					s_next.delay_len = pwdata[15:0];
			end
		end

		// stop key hold timer, restarted on release
		key_clear = 1'b0;
		if (!stop_key)
			s_next.key_ms = '0;
		else if (s_reg.tick && s_reg.key_ms != 11'(DFR_STOP_HOLD_MS))
		begin
			s_next.key_ms = s_reg.key_ms + 11'h001;
			key_clear = (s_reg.key_ms == KEY_LAST);
		end

		// selected digital input, 0 means none
		din_clear = (s_reg.din_sel != 4'h0) && (s_reg.din_sel <= 4'h8)
			&& din[3'(s_reg.din_sel - 4'h1)];

		clear = key_clear | din_clear | remote_clear;

		// warning flag: a new warning wins over standstill
		if (warn_in)
			s_next.warn = 1'b1;
		else if (motor_standstill)
			s_next.warn = 1'b0;

		// flash time base for the red indicator
		if (s_reg.tick)
		begin
			if (s_reg.blink_ms == BLINK_LAST)
			begin
				s_next.blink_ms = '0;
				s_next.blink = ~s_reg.blink;
			end
			else
				s_next.blink_ms = s_reg.blink_ms + 16'h0001;
		end

		// restart window: the count lapses once the window ends
		if (s_reg.rst_cnt != 8'h00 && s_reg.tick)
		begin
			if (s_reg.win_ms + 16'h0001 >= s_reg.win_len)
			begin
				s_next.rst_cnt = '0;
				s_next.win_ms = '0;
			end
			else
				s_next.win_ms = s_reg.win_ms + 16'h0001;
		end

		// supervisor state machine
		case (s_reg.st)
			DFR_ST_RUN:
			begin
				if (cause)
				begin
					s_next.st = DFR_ST_FAIL;
					s_next.code = new_code;
					s_next.auto_ok = new_auto;
				end
			end
			DFR_ST_FAIL:
			begin
				if (clear)
				begin
					s_next.manual = 1'b1;
					s_next.st = cause ? DFR_ST_READY : DFR_ST_RUN;
				end
				else if (!cause && s_reg.auto_ok && s_reg.rst_cnt < s_reg.max_cnt)
				begin
					s_next.manual = 1'b0;
					s_next.delay_ms = '0;
					s_next.st = DFR_ST_DELAY;
				end
			end
			DFR_ST_READY:
			begin
				if (!cause)
				begin
					s_next.delay_ms = '0;
					s_next.st = DFR_ST_DELAY;
				end
			end
			DFR_ST_DELAY:
			begin
				if (cause)
				begin
					s_next.st = DFR_ST_FAIL;
					s_next.code = new_code;
					s_next.auto_ok = new_auto;
				end
				else if (s_reg.tick)
				begin
					s_next.delay_ms = s_reg.delay_ms + 16'h0001;
					if (s_reg.delay_ms + 16'h0001 >= s_reg.delay_len)
					begin
						s_next.st = DFR_ST_RUN;
						if (!s_reg.manual && s_reg.rst_cnt != 8'hff)
						begin
							s_next.rst_cnt = s_next.rst_cnt + 8'h01;
							if (s_next.rst_cnt == 8'h01) // first counted restart opens window
								s_next.win_ms = '0;
						end
					end
				end
			end
			default:
				s_next.st = DFR_ST_FAIL;
		endcase

		// registered outputs follow the next state
		s_next.run = (s_next.st == DFR_ST_RUN);
		s_next.disp_fail = (s_next.st == DFR_ST_FAIL);
		s_next.disp_warn = (s_next.st == DFR_ST_RUN) && s_next.warn;
		s_next.ready = (s_next.st == DFR_ST_READY) || (s_next.st == DFR_ST_DELAY);
		if (s_next.st == DFR_ST_FAIL)
			s_next.led = 1'b1;
		else if (s_next.disp_warn)
			s_next.led = s_next.blink;
		else
			s_next.led = 1'b0;
	end

	// state register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_reg <= DFR_REGS_RST;
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign pready           = s_reg.pready;
	assign prdata           = s_reg.prdata;
	assign pslverr          = s_reg.pslverr;
	assign run_enable       = s_reg.run;
	assign red_led          = s_reg.led;
	assign show_failure     = s_reg.disp_fail;
	assign show_warning     = s_reg.disp_warn;
	assign ready_to_restart = s_reg.ready;
	assign failure_code     = s_reg.code;

endmodule

// File: verilog/dfr_pkg.sv
/*
 * dfr_pkg: shared constants for the drive fault restart supervisor:
 * register offsets, field layouts, failure codes, timing and state types.
 * Assumes a 125 MHz system clock and a 32-bit APB register bus.
 */
package dfr_pkg;

	// register byte offsets
	localparam logic [11:0] DFR_OFF_CTRL       = 12'h000;
	localparam logic [11:0] DFR_OFF_MAX_CNT    = 12'h004;
	localparam logic [11:0] DFR_OFF_WINDOW     = 12'h008;
	localparam logic [11:0] DFR_OFF_DELAY      = 12'h00c;
	localparam logic [11:0] DFR_OFF_REMOTE_CLR = 12'h010;
	localparam logic [11:0] DFR_OFF_STATUS     = 12'h014;

	// control register fields
	localparam int DFR_CTRL_REMOTE_BIT = 0;
	localparam int DFR_CTRL_DIN_LSB    = 4;
	localparam int DFR_CTRL_AUTO_LSB   = 8;
	localparam int DFR_DIN_SEL_W       = 4;
	localparam int DFR_AUTO_W          = 5;

	// auto restart enable bits, one per failure type except short circuit
	localparam int DFR_EN_LOW_UDC  = 0;
	localparam int DFR_EN_HIGH_UDC = 1;
	localparam int DFR_EN_HIGH_CUR = 2;
	localparam int DFR_EN_HEATSINK = 3;
	localparam int DFR_EN_ANALOG   = 4;

	// remote clear register: bit that must be written as one
	localparam int DFR_RCLR_BIT = 0;

	// status register fields
	localparam int DFR_STAT_ST_LSB    = 0;
	localparam int DFR_STAT_WARN_BIT  = 2;
	localparam int DFR_STAT_CAUSE_BIT = 3;
	localparam int DFR_STAT_CODE_LSB  = 4;
	localparam int DFR_STAT_CNT_LSB   = 8;
	localparam int DFR_STAT_ARM_BIT   = 16;

	// failure codes shown to the operator
	localparam logic [3:0] DFR_CODE_NONE     = 4'h0;
	localparam logic [3:0] DFR_CODE_HEATSINK = 4'h1;
	localparam logic [3:0] DFR_CODE_HIGH_UDC = 4'h3;
	localparam logic [3:0] DFR_CODE_LOW_UDC  = 4'h4;
	localparam logic [3:0] DFR_CODE_SHORT    = 4'h5;
	localparam logic [3:0] DFR_CODE_HIGH_CUR = 4'h6;
	localparam logic [3:0] DFR_CODE_ANALOG   = 4'h8;

	// timing: millisecond tick derived from the clock period
	localparam int DFR_CLK_PERIOD_NS = 8;
	localparam int DFR_TICK_NS       = 1000000;
	localparam int DFR_TICK_CYCLES   = DFR_TICK_NS / DFR_CLK_PERIOD_NS;
	localparam int DFR_STOP_HOLD_S   = 2;
	localparam int DFR_STOP_HOLD_MS  = DFR_STOP_HOLD_S * 1000;
	localparam int DFR_BLINK_HALF_MS = 250;

	// supervisor states
	typedef enum logic [1:0] {
		DFR_ST_RUN   = 2'b00,
		DFR_ST_FAIL  = 2'b01,
		DFR_ST_READY = 2'b10,
		DFR_ST_DELAY = 2'b11
	} dfr_state_t;

	// complete state of the supervisor
	typedef struct packed {
		dfr_state_t        st;
		logic [16:0]       tick_cnt;
		logic              tick;
		logic [10:0]       key_ms;
		logic [15:0]       blink_ms;
		logic              blink;
		logic              warn;
		logic [3:0]        code;
		logic              auto_ok;
		logic              manual;
		logic [15:0]       delay_ms;
		logic [15:0]       win_ms;
		logic [7:0]        rst_cnt;
		logic              remote_en;
		logic [3:0]        din_sel;
		logic [4:0]        auto_en;
		logic [7:0]        max_cnt;
		logic [15:0]       win_len;
		logic [15:0]       delay_len;
		logic              armed;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic              run;
		logic              led;
		logic              disp_fail;
		logic              disp_warn;
		logic              ready;
	} dfr_regs_t;

	localparam dfr_regs_t DFR_REGS_RST = '0;

endpackage

// File: tb/dfr_supervisor_properties.sv
/* dfr_sup_chk: port checker for the fault restart supervisor.
   assumes all inputs synchronous to clk_sys; bound below */
`timescale 1ns/1ps
module dfr_sup_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       fault_low_udc,
	input wire logic       fault_high_udc,
	input wire logic       fault_short,
	input wire logic       fault_high_cur,
	input wire logic       fault_heatsink,
	input wire logic       fault_analog,
	input wire logic       warn_in,
	input wire logic       motor_standstill,
	input wire logic       run_enable,
	input wire logic       red_led,
	input wire logic       show_failure,
	input wire logic       show_warning,
	input wire logic       ready_to_restart,
	input wire logic [3:0] failure_code
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// any failure cause present
	wire cause = fault_low_udc | fault_high_udc | fault_short | fault_high_cur
		| fault_heatsink | fault_analog;
	sequence hit_s;
		run_enable && cause;
	endsequence
	sequence hv_s;
		run_enable && fault_high_udc && !fault_short && !fault_high_cur;
	endsequence
	fail_stop_a: assert property (show_failure |-> !run_enable && red_led)
		else $error("failure without stop");
	fail_show_a: assert property (hit_s |=> show_failure)
		else $error("failure not shown");
	cause_hold_a: assert property (cause |=> !run_enable)
		else $error("running with cause");
	warn_run_a: assert property (show_warning |-> run_enable && !show_failure)
		else $error("warning stopped drive");
	warn_clr_a: assert property (motor_standstill && !warn_in |=> !show_warning)
		else $error("warning kept at standstill");
	ready_stop_a: assert property (ready_to_restart |-> !run_enable)
		else $error("ready state runs");
	code_three_a: assert property (hv_s |=> failure_code == 4'h3)
		else $error("bad high voltage code");
	code_five_a: assert property (run_enable && fault_short |=> failure_code == 4'h5)
		else $error("bad short code");
	code_six_a: assert property (run_enable && fault_high_cur && !fault_short
		|=> failure_code == 4'h6)
		else $error("bad current code");
	led_quiet_a: assert property (!show_failure && !show_warning |-> !red_led)
		else $error("red indicator lit without fault");
endmodule

bind dfr_supervisor dfr_sup_chk chk (.clk_sys(clk_sys), .rst(rst),
	.fault_low_udc(fault_low_udc), .fault_high_udc(fault_high_udc),
	.fault_short(fault_short), .fault_high_cur(fault_high_cur),
	.fault_heatsink(fault_heatsink), .fault_analog(fault_analog),
	.warn_in(warn_in), .motor_standstill(motor_standstill),
	.run_enable(run_enable), .red_led(red_led), .show_failure(show_failure),
	.show_warning(show_warning), .ready_to_restart(ready_to_restart),
	.failure_code(failure_code));

// File: tb/dfr_panel.sv
/* dfr_panel: operator panel model driving the stop key.
   assumes the bench calls hold just after a clock edge */
`timescale 1ns/1ps
module dfr_panel (
	input wire logic clk_sys,
	output logic     stop_key
);
	initial stop_key = 1'b0;
	// press, keep the key down n cycles, release
	task automatic hold(input int n);
		@(posedge clk_sys);
		stop_key <= 1'b1;
		repeat (n) @(posedge clk_sys);
		stop_key <= 1'b0;
	endtask
endmodule

// File: tb/test_dfr_supervisor.sv
/* test_dfr_supervisor: self-checking bench of the supervisor.
   assumes a 4-cycle ms tick so one ms is four clocks */
`timescale 1ns/1ps
module test_dfr_supervisor;
	import dfr_pkg::*;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, warn_in, stand;
	logic        run_enable, red_led, show_failure, show_warning, ready, stop_key;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, seed;
	logic [5:0]  flt;
	logic [7:0]  din;
	logic [3:0]  failure_code;
	logic [32:0] q[$];
	int          n_fail, num_checks;
	event        snap;

	dfr_supervisor #(.TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .fault_low_udc(flt[0]),
		.fault_high_udc(flt[1]), .fault_short(flt[2]), .fault_high_cur(flt[3]),
		.fault_heatsink(flt[4]), .fault_analog(flt[5]), .warn_in(warn_in),
		.motor_standstill(stand), .stop_key(stop_key), .din(din),
		.run_enable(run_enable), .red_led(red_led), .show_failure(show_failure),
		.show_warning(show_warning), .ready_to_restart(ready),
		.failure_code(failure_code));
	dfr_panel pnl (.clk_sys(clk_sys), .stop_key(stop_key));

	// clock
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// bits: run, failure, warning, ready, code
	task automatic look(input logic [7:0] e);
		q.push_back({25'h0, e});
		->snap;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (!pready) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// result monitors: read answers and output snapshots
	always @(posedge clk_sys)
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
	// snapshots are compared once the launching edge has settled
	always @(snap)
	begin
		#1;
		chk({25'h0, run_enable, show_failure, show_warning, ready, failure_code},
			q.pop_front());
	end

	// watchdog
	initial
	begin
		cyc(30000);
		n_fail++;
		conclude();
	end

	// main sequence
	initial
	begin
		seed = 32'hd210;
		{rst, psel, penable, pwrite, paddr, pwdata} = {2'b10, 46'h0};
		{flt, din, warn_in, stand} = 16'h0;
		cyc(6);
		rst <= 1'b0;
		din <= $random(seed) & 8'hfb;
		apb(1'b1, DFR_OFF_CTRL, 32'h231);
		apb(1'b1, DFR_OFF_MAX_CNT, 32'h1);
		rv = 32'h4000 | ($random(seed) & 32'h3fff);
		apb(1'b1, DFR_OFF_WINDOW, rv);
		rd(DFR_OFF_WINDOW, {1'b0, rv});
		apb(1'b1, DFR_OFF_DELAY, 32'h5);
		rd(12'h018, {1'b1, 32'h0});
		look(8'h80);
		// auto restart after delay
		flt[1] <= 1'b1;
		cyc(1);
		flt[1] <= 1'b0;
		look(8'h43);
		cyc(13);
		look(8'h13);
		cyc(20);
		look(8'h83);
		// limit reached, then remote pair
		flt[1] <= 1'b1;
		cyc(1);
		flt[1] <= 1'b0;
		cyc(100);
		look(8'h43);
		apb(1'b1, DFR_OFF_REMOTE_CLR, 32'h1);
		apb(1'b1, DFR_OFF_CTRL, 32'h231);
		apb(1'b1, DFR_OFF_REMOTE_CLR, 32'h1);
		cyc(1);
		look(8'h43);
		apb(1'b1, DFR_OFF_REMOTE_CLR, 32'h1);
		cyc(1);
		look(8'h83);
		// input clear with cause still present
		flt[2] <= 1'b1;
		cyc(1);
		look(8'h45);
		din <= 8'h04;
		cyc(2);
		look(8'h15);
		din <= 8'h00;
		flt[2] <= 1'b0;
		cyc(30);
		look(8'h85);
		// disabled type, stop key
		flt[3] <= 1'b1;
		cyc(1);
		flt[3] <= 1'b0;
		cyc(50);
		look(8'h46);
		pnl.hold(6000);
		cyc(2);
		pnl.hold(4000);
		look(8'h46);
		pnl.hold(8400);
		look(8'h86);
		// warning and standstill
		warn_in <= 1'b1;
		cyc(2);
		look(8'ha6);
		warn_in <= 1'b0;
		stand <= 1'b1;
		cyc(2);
		look(8'h86);
		// analog input fault: no auto restart, then input clear
		flt[5] <= 1'b1;
		cyc(1);
		flt[5] <= 1'b0;
		cyc(2);
		look(8'h48);
		din <= 8'h04;
		cyc(2);
		look(8'h88);
		din <= 8'h00;
		// status: one counted restart, code 8; then the window lapses
		rd(DFR_OFF_STATUS, {1'b0, 32'h180});
		apb(1'b1, DFR_OFF_WINDOW, 32'h1);
		cyc(8);
		rd(DFR_OFF_STATUS, {1'b0, 32'h080});
		cyc(2);
		conclude();
	end
endmodule
